// ==== prescale_if.sv ====
interface prescale_if;
  logic [2:0] select;   // prescale factor choice
  logic       restart;  // clears the divider
  logic       tick;     // one-cycle timer tick
  modport ctrl (output select, output restart, input tick);
  modport div  (input select, input restart, output tick);
endinterface

// ==== tb_timer8_waveform.sv ====
module tb_timer8_waveform;
  timeunit 1ns;
  timeprecision 1ns;
  import timer8_pkg::*;

  logic       clock_in, rst_in, psrst, cwr, mclr, oclr, pval, pdir;
  logic [1:0] mode, act;
  logic [2:0] psel;
  logic [7:0] cdat, cnt, cmp;
  logic       mflag, oflag, wave, pin, oe;
  int         fail_count, tests_run, hi, tg, n;
  // mode, action, compare, high cycles and toggles over two periods
  localparam logic [27:0] TBL [9] = '{
    {2'h3, 2'h2, 8'h00, 12'h002, 4'h4}, {2'h3, 2'h2, 8'h40, 12'h082, 4'h4},
    {2'h3, 2'h2, 8'hFF, 12'h200, 4'h0}, {2'h3, 2'h3, 8'h40, 12'h17E, 4'h4},
    {2'h3, 2'h1, 8'h40, 12'h100, 4'h2}, {2'h1, 2'h2, 8'h00, 12'h000, 4'h0},
    {2'h1, 2'h2, 8'h40, 12'h100, 4'h4}, {2'h1, 2'h2, 8'hFF, 12'h3FC, 4'h0},
    {2'h1, 2'h3, 8'h40, 12'h2FC, 4'h4}};
  localparam int DIV [7] = '{1, 8, 32, 64, 128, 256, 1024};

  timer8_waveform uut (
    .clock_in                 (clock_in),
    .rst_in                   (rst_in),
    .waveform_mode_sel_in     (mode),
    .compare_output_action_in (act),
    .prescale_sel_in          (psel),
    .prescale_reset_in        (psrst),
    .compare_write_in         (cwr),
    .compare_data_in          (cdat),
    .match_flag_clear_in      (mclr),
    .overflow_clear_in        (oclr),
    .port_value_in            (pval),
    .port_dir_out_in          (pdir),
    .count_value_out          (cnt),
    .compare_value_out        (cmp),
    .compare_match_flag_out   (mflag),
    .overflow_flag_out        (oflag),
    .waveform_out             (wave),
    .pin_out                  (pin),
    .pin_oe_out               (oe));

  ////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // a hang would stall the run, so cut it well past the expected length
  initial begin
    #(CLOCK_PERIOD_NS * 60000);
    fail_count++;
    $display("Error watchdog expected 0 seen 1");
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // all driving happens on falling edges, away from the sampling edge
  task automatic cyc(int k);
    repeat (k) @(negedge clock_in);
  endtask

  // bounded wait for the next cycle showing count v
  task automatic wait_cnt(logic [7:0] v);
    int i;
    i = 0;
    do begin
      cyc(1);
      i++;
    end while (cnt !== v && i < 3000);
    if (i == 3000)
      chk("count wait", v, cnt);
  endtask

  task automatic wr(logic [7:0] v);
    cdat = v;
    cwr  = 1'b1;
    cyc(1);
    cwr  = 1'b0;
  endtask

  task automatic pulse_oclr();
    oclr = 1'b1;
    cyc(1);
    oclr = 1'b0;
  endtask

  // high cycles and level changes of the waveform over w cycles
  task automatic meas(int w);
    logic last;
    hi = 0;
    tg = 0;
    last = wave;
    repeat (w) begin
      cyc(1);
      if (wave === 1'b1)
        hi++;
      if (wave !== last)
        tg++;
      last = wave;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_in, psrst, cwr, mclr, oclr, pval, pdir} = 7'h40;
    {mode, act, psel, cdat} = 15'h0000;
    fail_count = 0;
    tests_run = 0;
    cyc(2);
    chk("reset outputs", 32'h0, {cnt, cmp, mflag, oflag, wave, pin, oe});
    rst_in = 1'b0;
    // clear on match: wrap at compare, match flag one tick later
    mode = MODE_CLEAR_MATCH;
    act = ACT_TOGGLE;
    psel = 3'h1;
    wr(8'h03);
    chk("compare direct", 8'h03, cmp);
    wait_cnt(8'h02);
    mclr = 1'b1;
    cyc(1);
    mclr = 1'b0;
    chk("match flag early", 1'b0, mflag);
    cyc(1);
    chk("count cleared", 8'h00, cnt);
    cyc(1);
    chk("match flag", 1'b1, mflag);
    $display("test clear_on_match done");
    // pin routing, with the counter stopped so the output holds
    psel = PRESCALE_STOP;
    pdir = 1'b1;
    cyc(3);
    chk("pin follows wave", 3'h7, {oe, pin, wave});
    pdir = 1'b0;
    cyc(3);
    chk("pin released", 1'b0, oe);
    {act, pdir, pval} = 4'h3;
    cyc(3);
    chk("port level high", 2'h3, {oe, pin});
    pval = 1'b0;
    cyc(3);
    chk("port level low", 1'b0, pin);
    $display("test pin done");
    // toggle rate against prescale and compare
    act = ACT_TOGGLE;
    for (int i = 0; i < 7; i++) begin
      psel = 3'h1;
      wr((i == 0) ? 8'h02 : 8'h00);
      cyc(300);
      psel = 3'(i + 1);
      psrst = 1'b1;
      cyc(1);
      psrst = 1'b0;
      cyc(2 * DIV[i] + 10);
      meas((i == 0) ? 2046 : 2048);
      chk("toggles", (i == 0) ? 682 : 2048 / DIV[i], tg);
    end
    $display("test prescale done");
    // late write below the count must run through 0xFF first
    psel = 3'h1;
    wr(8'h80);
    wait_cnt(8'h60);
    pulse_oclr();
    wr(8'h10);
    chk("compare direct", 8'h10, cmp);
    wait_cnt(8'hFF);
    chk("overflow early", 1'b0, oflag);
    cyc(2);
    chk("overflow wrap", 9'h101, {oflag, cnt});
    wait_cnt(8'h10);
    cyc(1);
    chk("late match clears", 8'h00, cnt);
    $display("test late write done");
    // pwm duty and toggles for both pwm modes and the extremes
    for (int i = 0; i < 9; i++) begin
      {mode, act} = TBL[i][27:24];
      wr(TBL[i][23:16]);
      cyc(1100);
      n = (mode == MODE_FAST) ? 512 : 2 * PHASE_PERIOD;
      meas(n);
      chk("high cycles", TBL[i][15:4], hi);
      chk("level changes", TBL[i][3:0], tg);
    end
    $display("test duty done");
    // fast mode: buffered compare loads at bottom, overflow at max
    mode = MODE_FAST;
    act = ACT_CLEAR;
    wr(8'h40);
    cyc(600);
    wait_cnt(8'h80);
    wr(8'h20);
    chk("compare held", 8'h40, cmp);
    pulse_oclr();
    wait_cnt(8'hFE);
    chk("fast before max", 9'h040, {oflag, cmp});
    cyc(1);
    chk("fast at max", 9'h1FF, {oflag, cnt});
    cyc(1);
    chk("fast bottom", 16'h0020, {cnt, cmp});
    $display("test fast buffer done");
    // phase mode: load at max, max held one tick, overflow at bottom
    mode = MODE_PHASE;
    wr(8'h40);
    cyc(1100);
    wait_cnt(8'h00);
    wait_cnt(8'h10);
    wr(8'h30);
    chk("compare held", 8'h40, cmp);
    pulse_oclr();
    wait_cnt(8'hFE);
    chk("phase before max", 9'h040, {oflag, cmp});
    cyc(1);
    chk("phase at max", 16'hFF30, {cnt, cmp});
    cyc(1);
    chk("phase turns", 8'hFE, cnt);
    wait_cnt(8'h00);
    cyc(1);
    chk("phase overflow", 9'h101, {oflag, cnt});
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (cnt !== 8'h00 && n < 600);
    chk("phase period", PHASE_PERIOD - 1, n);
    $display("test phase buffer done");
    // normal mode passes the compare value without clearing
    mode = MODE_NORMAL;
    act = ACT_SET;
    wr(8'h20);
    wait_cnt(8'h20);
    cyc(1);
    chk("normal no clear", 9'h121, {wave, cnt});
    $display("test normal done");
    stop_test();
  end
endmodule

// ==== timer8_pkg.sv ====
package timer8_pkg;
  // waveform mode select codes
  localparam logic [1:0] MODE_NORMAL       = 2'h0;
  localparam logic [1:0] MODE_PHASE        = 2'h1;
  localparam logic [1:0] MODE_CLEAR_MATCH  = 2'h2;
  localparam logic [1:0] MODE_FAST         = 2'h3;
  // compare output action codes
  localparam logic [1:0] ACT_OFF           = 2'h0;
  localparam logic [1:0] ACT_TOGGLE        = 2'h1;
  localparam logic [1:0] ACT_CLEAR         = 2'h2;
  localparam logic [1:0] ACT_SET           = 2'h3;
  // counter extremes and reset values
  localparam logic [7:0] COUNT_BOTTOM      = 8'h00;
  localparam logic [7:0] COUNT_MAX         = 8'hFF;
  localparam logic [7:0] COMPARE_RESET     = 8'h00;
  // prescale selects: 0 stop, 1 /1, 2 /8, 3 /32, 4 /64, 5 /128, 6 /256, 7 /1024
  localparam logic [2:0] PRESCALE_STOP     = 3'h0;
  localparam int         PRESCALE_BITS     = 10;
  localparam int         PHASE_PERIOD      = 510;
  localparam int         CLOCK_PERIOD_NS   = 40;
endpackage

// ==== timer8_prescaler.sv ====
module timer8_prescaler
  import timer8_pkg::*;
(
  input  wire logic clock_in,  // i/o clock
  input  wire logic rst_in,    // synchronous reset, high
  prescale_if.div   ps         // select in, tick out
);
  typedef struct packed {
    logic [PRESCALE_BITS-1:0] div;
    logic                     tick;
  } pstate_type;

  pstate_type st_q, st_d;
  logic [PRESCALE_BITS-1:0] nxt;

  // free divider; a tick marks each wrap of the chosen tap
  always_comb begin
    st_d = st_q;
    nxt  = st_q.div + 1'b1;
    st_d.div = ps.restart ? '0 : nxt;
    unique case (ps.select)
      3'h0: st_d.tick = 1'b0;
      3'h1: st_d.tick = 1'b1;
      3'h2: st_d.tick = (st_q.div[2:0] == 3'h7);
      3'h3: st_d.tick = (st_q.div[4:0] == 5'h1F);
      3'h4: st_d.tick = (st_q.div[5:0] == 6'h3F);
      3'h5: st_d.tick = (st_q.div[6:0] == 7'h7F);
      3'h6: st_d.tick = (st_q.div[7:0] == 8'hFF);
      3'h7: st_d.tick = (st_q.div == 10'h3FF);
    endcase
    if (ps.restart && ps.select != 3'h1) st_d.tick = 1'b0;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) st_q <= '0;
    else        st_q <= st_d;
  end

  assign ps.tick = st_q.tick;

  property p_tick_stop;
    @(posedge clock_in) disable iff (rst_in)
      (ps.select == PRESCALE_STOP) [*2] |-> !ps.tick;
  endproperty
  a_tick_stop: assert property (p_tick_stop)
    else $error("tick while stopped");
endmodule

// ==== timer8_waveform.sv ====
// Summary of operation
// - mode 2 clears counter at compare match
// - mode 2 compare unbuffered, late write wraps
// - mode 2 action 1 toggles on match
// - output toggles every N*(1+compare) clocks
// - tick is clock divided by 1..1024
// - mode 2 overflow when MAX wraps to zero
// - mode 3 counts bottom to MAX, restarts
// - fast actions 2/3 clear/set at match
// - fast mode overflow at MAX
// - fast extremes: spike or constant level
// - fast action 1 toggles, half duty
// - fast mode compare writes are buffered
// - mode 1 counts up, holds MAX, down
// - phase action 2 match clears up, sets down; 3 reverses
// - phase mode overflow at bottom
// - phase extremes hold output low or high
// - phase period is 510 ticks
// - mode 2 match flag at top
// - pin driven only when direction is output
// - tick is a clock enable of clock_in
// - match flag sets on next tick
// - buffer loads only at top or bottom
// - action 0 leaves pin to the port
module timer8_waveform
  import timer8_pkg::*;
(
  input  wire logic       clock_in,            // i/o clock, 25 MHz
  input  wire logic       rst_in,              // synchronous reset, high
  input  wire logic [1:0] waveform_mode_sel_in,   // counting mode
  input  wire logic [1:0] compare_output_action_in, // output action
  input  wire logic [2:0] prescale_sel_in,     // 0 stop, 1..7 divide
  input  wire logic       prescale_reset_in,   // restart divider
  input  wire logic       compare_write_in,    // compare write strobe
  input  wire logic [7:0] compare_data_in,     // compare write data
  input  wire logic       match_flag_clear_in, // clear match flag
  input  wire logic       overflow_clear_in,   // clear overflow flag
  input  wire logic       port_value_in,       // normal port level
  input  wire logic       port_dir_out_in,     // pin direction: 1 output
  output logic [7:0]      count_value_out,     // counter
  output logic [7:0]      compare_value_out,   // active compare
  output logic            compare_match_flag_out, // sticky match flag
  output logic            overflow_flag_out,   // sticky overflow flag
  output logic            waveform_out,        // internal output state
  output logic            pin_out,             // pin level
  output logic            pin_oe_out           // pin driven
);
  typedef struct packed {
    logic [7:0] count;
    logic       down;
    logic [7:0] compare;
    logic [7:0] buffer;
    logic       match_pend;
    logic       match_flag;
    logic       overflow;
    logic       wave;
    logic       pin;
    logic       pin_oe;
  } state_type;

  state_type st_q, st_d;
  prescale_if ps ();
  logic tick;
  logic hit;
  logic ovf_set;                                  // overflow event this cycle
  logic [1:0] act;

  //////////////////////////////////////////////////////////////////////////
  // prescaler, a clock enable in this one domain
  assign ps.select  = prescale_sel_in;
  assign ps.restart = prescale_reset_in;
  assign tick       = ps.tick;

  timer8_prescaler u_prescaler (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .ps       (ps)
  );

  //////////////////////////////////////////////////////////////////////////
  // counting, compare and output logic
  always_comb begin
    st_d = st_q;
    act  = compare_output_action_in;
    hit  = (st_q.count == st_q.compare);
    ovf_set = 1'b0;
    // compare writes: direct in non-pwm modes, buffered in pwm modes
    if (compare_write_in) begin
      st_d.buffer = compare_data_in;
      if (waveform_mode_sel_in[0] == 1'b0)
        st_d.compare = compare_data_in;
    end
    if (tick) begin
      st_d.match_pend = hit;
      if (st_q.match_pend) st_d.match_flag = 1'b1;
      unique case (waveform_mode_sel_in)
        MODE_NORMAL: begin
          st_d.count = st_q.count + 8'h01;
          if (st_q.count == COUNT_MAX) ovf_set = 1'b1;
          if (hit && act != ACT_OFF)
            st_d.wave = (act == ACT_TOGGLE) ? ~st_q.wave : act[0];
        end
        MODE_CLEAR_MATCH: begin
          // clear at match; a compare below count wraps through MAX
          st_d.count = hit ? COUNT_BOTTOM
                           : st_q.count + 8'h01;
          if (st_q.count == COUNT_MAX && !hit)
            ovf_set = 1'b1;
          if (hit && act != ACT_OFF)
            st_d.wave = (act == ACT_TOGGLE) ? ~st_q.wave : act[0];
        end
        MODE_FAST: begin
          st_d.count = st_q.count + 8'h01;
          if (st_q.count == COUNT_MAX) begin
            st_d.compare = st_q.buffer;
            // non-inverting sets at bottom, inverting clears
            if (act[1]) st_d.wave = ~act[0];
          end
          if (st_d.count == COUNT_MAX) ovf_set = 1'b1;
          // match after the bottom update so compare MAX holds level
          if (hit) begin
            if (act == ACT_TOGGLE) st_d.wave = ~st_q.wave;
            else if (act[1] && st_q.compare != COUNT_MAX)
              st_d.wave = act[0];
          end
        end
        MODE_PHASE: begin
          // up to MAX, one tick there, then down to bottom
          if (!st_q.down) begin
            if (st_q.count == COUNT_MAX) begin
              st_d.down    = 1'b1;
              st_d.count   = st_q.count - 8'h01;
            end else
              st_d.count   = st_q.count + 8'h01;
          end else if (st_q.count == COUNT_BOTTOM) begin
            st_d.down  = 1'b0;
            st_d.count = st_q.count + 8'h01;
          end else
            st_d.count = st_q.count - 8'h01;
          if (st_d.count == COUNT_MAX) st_d.compare = st_q.buffer;
          if (st_d.count == COUNT_BOTTOM && st_q.down)
            ovf_set = 1'b1;
          // extremes: bottom stays low, MAX stays high (non-inverting)
          if (act[1]) begin
            if (st_q.compare == COUNT_BOTTOM)
              st_d.wave = act[0];
            else if (st_q.compare == COUNT_MAX)
              st_d.wave = ~act[0];
            else if (hit)
              st_d.wave = st_q.down ? ~act[0] : act[0];
          end
        end
      endcase
    end
    // hardware set wins over the clear
    if (match_flag_clear_in && !(tick && st_q.match_pend))
      st_d.match_flag = 1'b0;
    if (ovf_set)
      st_d.overflow = 1'b1;
    else if (overflow_clear_in)
      st_d.overflow = 1'b0;
    // pin mux: action 0 returns pin to the port
    st_d.pin    = (act == ACT_OFF) ? port_value_in : st_d.wave;
    st_d.pin_oe = port_dir_out_in;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_q         <= '0;
      st_q.compare <= COMPARE_RESET;
      st_q.buffer  <= COMPARE_RESET;
    end else
      st_q <= st_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign count_value_out        = st_q.count;
  assign compare_value_out      = st_q.compare;
  assign compare_match_flag_out = st_q.match_flag;
  assign overflow_flag_out      = st_q.overflow;
  assign waveform_out           = st_q.wave;
  assign pin_out                = st_q.pin;
  assign pin_oe_out             = st_q.pin_oe;

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_ctc_clear;
    @(posedge clock_in) disable iff (rst_in)
      tick && waveform_mode_sel_in == MODE_CLEAR_MATCH &&
      st_q.count == st_q.compare |=> st_q.count == COUNT_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear)
    else $error("count not cleared at match");

  property p_ctc_toggle;
    @(posedge clock_in) disable iff (rst_in)
      tick && waveform_mode_sel_in == MODE_CLEAR_MATCH && hit &&
      compare_output_action_in == ACT_TOGGLE |=> st_q.wave != $past(st_q.wave);
  endproperty
  a_ctc_toggle: assert property (p_ctc_toggle)
    else $error("output did not toggle");

  property p_match_next;
    @(posedge clock_in) disable iff (rst_in)
      tick && st_q.match_pend |=> st_q.match_flag;
  endproperty
  a_match_next: assert property (p_match_next)
    else $error("match flag late");

  property p_fast_wrap;
    @(posedge clock_in) disable iff (rst_in)
      tick && waveform_mode_sel_in == MODE_FAST && st_q.count == COUNT_MAX
      |=> st_q.count == COUNT_BOTTOM && st_q.compare == $past(st_q.buffer);
  endproperty
  a_fast_wrap: assert property (p_fast_wrap)
    else $error("fast wrap or buffer load wrong");

  property p_fast_ovf;
    @(posedge clock_in) disable iff (rst_in)
      tick && waveform_mode_sel_in == MODE_FAST &&
      st_q.count == 8'hFE |=> st_q.overflow;
  endproperty
  a_fast_ovf: assert property (p_fast_ovf)
    else $error("overflow missing at MAX");

  property p_phase_turn;
    @(posedge clock_in) disable iff (rst_in)
      tick && waveform_mode_sel_in == MODE_PHASE && !st_q.down &&
      st_q.count == COUNT_MAX |=> st_q.down && st_q.count == 8'hFE;
  endproperty
  a_phase_turn: assert property (p_phase_turn)
    else $error("phase turn wrong");

  property p_phase_ovf;
    @(posedge clock_in) disable iff (rst_in)
      tick && waveform_mode_sel_in == MODE_PHASE && st_q.down &&
      st_q.count == 8'h01 |=> st_q.overflow;
  endproperty
  a_phase_ovf: assert property (p_phase_ovf)
    else $error("overflow missing at bottom");

  property p_pin_dir;
    @(posedge clock_in) disable iff (rst_in)
      1'b1 |=> pin_oe_out == $past(port_dir_out_in);
  endproperty
  a_pin_dir: assert property (p_pin_dir)
    else $error("pin enable not following direction");

  property p_direct_write;
    @(posedge clock_in) disable iff (rst_in)
      compare_write_in && waveform_mode_sel_in == MODE_CLEAR_MATCH
      |=> st_q.compare == $past(compare_data_in);
  endproperty
  a_direct_write: assert property (p_direct_write)
    else $error("unbuffered write lost");

  property p_ctc_flag;
    @(posedge clock_in) disable iff (rst_in)
      tick && waveform_mode_sel_in == MODE_CLEAR_MATCH && hit
      |=> st_q.match_pend;
  endproperty
  a_ctc_flag: assert property (p_ctc_flag)
    else $error("match at top not noted");

  property p_fast_bottom;
    @(posedge clock_in) disable iff (rst_in)
      tick && waveform_mode_sel_in == MODE_FAST &&
      st_q.count == COUNT_MAX && compare_output_action_in[1]
      |=> st_q.wave == !$past(compare_output_action_in[0]);
  endproperty
  a_fast_bottom: assert property (p_fast_bottom)
    else $error("fast level at bottom wrong");

  property p_fast_match;
    @(posedge clock_in) disable iff (rst_in)
      tick && waveform_mode_sel_in == MODE_FAST && hit &&
      compare_output_action_in[1] && st_q.compare != COUNT_MAX
      |=> st_q.wave == $past(compare_output_action_in[0]);
  endproperty
  a_fast_match: assert property (p_fast_match)
    else $error("fast level at match wrong");

  property p_fast_buffered;
    @(posedge clock_in) disable iff (rst_in)
      compare_write_in && waveform_mode_sel_in == MODE_FAST &&
      !(tick && st_q.count == COUNT_MAX) |=> $stable(st_q.compare);
  endproperty
  a_fast_buffered: assert property (p_fast_buffered)
    else $error("buffered write reached compare");

  property p_phase_low;
    @(posedge clock_in) disable iff (rst_in)
      tick && waveform_mode_sel_in == MODE_PHASE &&
      compare_output_action_in[1] && st_q.compare == COUNT_BOTTOM
      |=> st_q.wave == $past(compare_output_action_in[0]);
  endproperty
  a_phase_low: assert property (p_phase_low)
    else $error("phase bottom extreme wrong");

  property p_phase_high;
    @(posedge clock_in) disable iff (rst_in)
      tick && waveform_mode_sel_in == MODE_PHASE &&
      compare_output_action_in[1] && st_q.compare == COUNT_MAX
      |=> st_q.wave == !$past(compare_output_action_in[0]);
  endproperty
  a_phase_high: assert property (p_phase_high)
    else $error("phase max extreme wrong");

  property p_phase_match;
    @(posedge clock_in) disable iff (rst_in)
      tick && waveform_mode_sel_in == MODE_PHASE && hit &&
      compare_output_action_in[1] && st_q.compare != COUNT_BOTTOM &&
      st_q.compare != COUNT_MAX
      |=> st_q.wave == ($past(st_q.down) ^
                        $past(compare_output_action_in[0]));
  endproperty
  a_phase_match: assert property (p_phase_match)
    else $error("phase match level wrong");

  property p_pin_port;
    @(posedge clock_in) disable iff (rst_in)
      compare_output_action_in == ACT_OFF
      |=> pin_out == $past(port_value_in);
  endproperty
  a_pin_port: assert property (p_pin_port)
    else $error("pin not returned to port");
endmodule
